// ==== common/prox_pkg.sv ====
// constants, register map and carrier types for the proximity and ambient threshold block
package prox_pkg;

  localparam int DATA_W = 16;
  localparam int STAGE_W = 4;
  localparam int NUM_STAGES = 12;
  localparam int ADDR_W = 10;
  localparam int FF_DEPTH = 4;
  localparam int CALDIS_W = 8;

  // register offsets (word index on the plain register port)
  localparam logic [ADDR_W-1:0] PROX_CTRL_ADDR = 10'h002;
  localparam logic [ADDR_W-1:0] AMB_CTRL_ADDR = 10'h003;
  localparam logic [ADDR_W-1:0] MODE_ADDR = 10'h080;
  localparam logic [ADDR_W-1:0] SLOW_LVL_ADDR = 10'h081;
  localparam logic [ADDR_W-1:0] SENS_ADDR = 10'h082;
  localparam logic [ADDR_W-1:0] STAGE_SEL_ADDR = 10'h083;
  localparam logic [ADDR_W-1:0] UPPER_OFFSET_ADDR = 10'h084;
  localparam logic [ADDR_W-1:0] LOWER_OFFSET_ADDR = 10'h085;
  localparam logic [ADDR_W-1:0] AMBIENT_ADDR = 10'h086;
  localparam logic [ADDR_W-1:0] UPPER_LIMIT_ADDR = 10'h087;
  localparam logic [ADDR_W-1:0] LOWER_LIMIT_ADDR = 10'h088;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 10'h089;
  localparam logic [ADDR_W-1:0] MASK_ADDR = 10'h08a;
  localparam logic [ADDR_W-1:0] PROX_FLAGS_ADDR = 10'h08b;
  localparam logic [ADDR_W-1:0] SLOW_NEWEST_ADDR = 10'h08c;

  // field positions
  localparam int FAST_SKIP_LSB = 0;
  localparam int FP_CALDIS_LSB = 4;
  localparam int LP_CALDIS_LSB = 8;
  localparam int RECAL_LVL_LSB = 0;
  localparam int DET_RATE_LSB = 8;
  localparam int LOW_POWER_BIT = 0;
  localparam int SEQ_NUM_LSB = 1;
  localparam int POS_SENS_LSB = 0;
  localparam int NEG_SENS_LSB = 4;

  // status bits
  localparam int ST_UPPER_BIT = 0;
  localparam int ST_LOWER_BIT = 1;
  localparam int ST_PROX_BIT = 2;
  localparam int STATUS_W = 3;

  // arithmetic constants
  localparam int LEVEL_SHIFT = 4;
  localparam int FP_CALDIS_SHIFT = 4;
  localparam int LP_CALDIS_SHIFT = 2;
  localparam int THR_DIV_SHIFT = 2;
  localparam int AMB_FILTER_SHIFT = 4;

  // reset values
  localparam logic [15:0] PROX_CTRL_RST = 16'h0000;
  localparam logic [15:0] AMB_CTRL_RST = 16'h0000;
  localparam logic [15:0] MODE_RST = 16'h0016;
  localparam logic [15:0] SLOW_LVL_RST = 16'h0000;
  localparam logic [7:0] SENS_RST = 8'h88;
  localparam logic [DATA_W-1:0] UPPER_LIMIT_RST = 16'hffff;
  localparam logic [DATA_W-1:0] LOWER_LIMIT_RST = 16'h0000;

  typedef struct packed {
    logic valid;
    logic [STAGE_W-1:0] stage;
    logic [DATA_W-1:0] data;
  } conv_result_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : prox_pkg

// ==== logic/abs_diff_cmp.sv ====
// absolute-difference comparator against a scaled level
`timescale 1ns/1ps
module abs_diff_cmp #(
  parameter int W = 16,
  parameter int LVL_W = 8,
  parameter int SHIFT = 4
) (
  input wire logic [W-1:0] a_in,
  input wire logic [W-1:0] b_in,
  input wire logic [LVL_W-1:0] level_in,
  output logic exceeds_out
);
  logic [W-1:0] diff;
  logic [W+LVL_W+SHIFT-1:0] scaled;
  always_comb begin
    diff = (a_in >= b_in) ? (a_in - b_in) : (b_in - a_in);
    scaled = (W+LVL_W+SHIFT)'(level_in) << SHIFT;
    exceeds_out = {{(LVL_W+SHIFT){1'b0}}, diff} > scaled;
  end
endmodule : abs_diff_cmp

// ==== logic/proximity_ambient_threshold_logic.sv ====
// per-stage proximity detection, ambient tracking and threshold logic
// Notes on behaviour
// - fast skip count, bits 3..0 of register 0x002, sets samples dropped before fast FIFO
// - fast FIFO fills once per (skip+1) sequences; sequence ends at stage number in bits 4..1 of register 0x080
// - slow path switch closes when new result departs slow newest by level, no proximity, no hold-off
// - approach flag when |fast first - fast fourth| exceeds approach rate level
// - hover flag when |fast average - ambient| exceeds hover recal level
// - ambient filter updates only with slow enable set and proximity clear
// - compensation runs on every conversion automatically, no host request
// - upper and lower limits recomputed from tracked ambient each conversion
// - per-stage state and offsets kept in on-chip arrays; controls via registers
// - active-low interrupt when result crosses stage upper or lower limit
// - upper limit = ambient + off/4 + ((off - off/4)/4) * positive sensitivity
// - lower limit = ambient + off/4 + ((off - off/4)/4) * negative sensitivity
// - ambient tracked only from results taken without approach or hover
// - approach and hover levels scaled by sixteen before comparing
// - combined proximity is approach or hover
// - calibration held off during proximity and full-power count*16 sequences after
// - in low power the hold-off after proximity is count*4 sequences
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
module proximity_ambient_threshold_logic
  import prox_pkg::*;
#(
  parameter int N_STAGES = NUM_STAGES
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic res_valid_in,
  input wire logic [STAGE_W-1:0] res_stage_in,
  input wire logic [DATA_W-1:0] res_data_in,
  output logic int_n_out,
  output logic proximity_out,
  output logic slow_path_switch_out
);

  reg_req_t req;
  conv_result_t res;

  // control registers
  logic [15:0] prox_ctrl_r, prox_ctrl_nxt;
  logic [15:0] amb_ctrl_r, amb_ctrl_nxt;
  logic [15:0] mode_r, mode_nxt;
  logic [15:0] slow_lvl_r, slow_lvl_nxt;
  logic [7:0] sens_r, sens_nxt;
  logic [STAGE_W-1:0] sel_r, sel_nxt;
  logic [STATUS_W-1:0] status_r, status_nxt;
  logic [STATUS_W-1:0] mask_r, mask_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic int_n_r, int_n_nxt;
  logic prox_out_r, prox_out_nxt;
  logic sw_r, sw_nxt;
  logic [3:0] skip_cnt_r, skip_cnt_nxt;

  // per-stage on-chip state
  logic [DATA_W-1:0] ff_mem [N_STAGES][FF_DEPTH];
  logic [DATA_W-1:0] slow_mem [N_STAGES];
  logic [DATA_W-1:0] amb_mem [N_STAGES];
  logic [DATA_W-1:0] uoff_mem [N_STAGES];
  logic [DATA_W-1:0] loff_mem [N_STAGES];
  logic [DATA_W-1:0] ulim_mem [N_STAGES];
  logic [DATA_W-1:0] llim_mem [N_STAGES];
  logic [CALDIS_W-1:0] caldis_mem [N_STAGES];
  logic [N_STAGES-1:0] prox_vec_r, prox_vec_nxt;

  // control fields
  logic [3:0] fast_skip_count;
  logic [3:0] full_power_caldis_count;
  logic [3:0] low_power_caldis_count;
  logic [7:0] hover_recal_level;
  logic [5:0] approach_rate_level;
  logic low_power;
  logic [3:0] seq_stage_num;
  logic [3:0] positive_sensitivity;
  logic [3:0] negative_sensitivity;

  // datapath
  logic stage_ok;
  logic [STAGE_W-1:0] st;
  logic fast_wr;
  logic seq_end;
  logic [DATA_W-1:0] fast_fifo_first, fast_fifo_fourth;
  logic [DATA_W-1:0] ff_new [FF_DEPTH];
  logic [DATA_W+1:0] ff_sum;
  logic [DATA_W-1:0] ff_avg;
  logic [DATA_W-1:0] slow_fifo_newest;
  logic [DATA_W-1:0] stage_ambient_estimate, amb_new;
  logic [DATA_W:0] amb_delta, amb_step;
  logic [DATA_W-1:0] stage_upper_limit, stage_lower_limit;
  logic [DATA_W-1:0] ulim_new, llim_new;
  logic [CALDIS_W-1:0] caldis_cur, caldis_new, caldis_load;
  logic approach_hit, hover_hit, slow_diff_hit;
  logic prox, slow_en, cal_ok, amb_upd;
  logic cross_up, cross_low, prox_rise;

  // 16-bit limit from ambient, offset and sensitivity, saturating
  function automatic logic [DATA_W-1:0] limit_calc(input logic [DATA_W-1:0] amb,
                                                   input logic [DATA_W-1:0] off,
                                                   input logic [3:0] sens);
    logic [DATA_W-1:0] quarter;
    logic [DATA_W-1:0] rest;
    logic [DATA_W+4:0] sum;
    quarter = off >> THR_DIV_SHIFT;
    rest = (off - quarter) >> THR_DIV_SHIFT;
    sum = {5'h00, amb} + {5'h00, quarter} + ({5'h00, rest} * {17'h00000, sens});
    limit_calc = (sum > {5'h00, 16'hffff}) ? 16'hffff : sum[DATA_W-1:0];
  endfunction : limit_calc

  always_comb begin
    req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
    res = '{valid: res_valid_in, stage: res_stage_in, data: res_data_in};
    fast_skip_count = prox_ctrl_r[FAST_SKIP_LSB +: 4];
    full_power_caldis_count = prox_ctrl_r[FP_CALDIS_LSB +: 4];
    low_power_caldis_count = prox_ctrl_r[LP_CALDIS_LSB +: 4];
    hover_recal_level = amb_ctrl_r[RECAL_LVL_LSB +: 8];
    approach_rate_level = amb_ctrl_r[DET_RATE_LSB +: 6];
    low_power = mode_r[LOW_POWER_BIT];
    seq_stage_num = mode_r[SEQ_NUM_LSB +: 4];
    positive_sensitivity = sens_r[POS_SENS_LSB +: 4];
    negative_sensitivity = sens_r[NEG_SENS_LSB +: 4];
  end

  // per-result read of the stage state
  always_comb begin
    stage_ok = res.valid && ({28'h0000000, res.stage} < N_STAGES);
    st = stage_ok ? res.stage : '0;
    seq_end = stage_ok && (res.stage == seq_stage_num);
    fast_wr = stage_ok && (skip_cnt_r == fast_skip_count);
    // word 0 takes the new result and older words move up one place;
    // a skipped sample leaves all four words as they were
    ff_new[0] = fast_wr ? res.data : ff_mem[st][0];
    for (int k = 1; k < FF_DEPTH; k++) begin
      ff_new[k] = fast_wr ? ff_mem[st][k-1] : ff_mem[st][k];
    end
    fast_fifo_first = ff_new[0];
    fast_fifo_fourth = ff_new[FF_DEPTH-1];
    ff_sum = {2'b00, ff_new[0]} + {2'b00, ff_new[1]} + {2'b00, ff_new[2]} + {2'b00, ff_new[3]};
    ff_avg = ff_sum[DATA_W+1:2];
    slow_fifo_newest = slow_mem[st];
    stage_ambient_estimate = amb_mem[st];
    stage_upper_limit = ulim_mem[st];
    stage_lower_limit = llim_mem[st];
    caldis_cur = caldis_mem[st];
  end

  abs_diff_cmp #(.W(DATA_W), .LVL_W(6), .SHIFT(LEVEL_SHIFT)) approach_cmp (
    .a_in(fast_fifo_first),
    .b_in(fast_fifo_fourth),
    .level_in(approach_rate_level),
    .exceeds_out(approach_hit)
  );

  abs_diff_cmp #(.W(DATA_W), .LVL_W(8), .SHIFT(LEVEL_SHIFT)) hover_cmp (
    .a_in(ff_avg),
    .b_in(stage_ambient_estimate),
    .level_in(hover_recal_level),
    .exceeds_out(hover_hit)
  );

  abs_diff_cmp #(.W(DATA_W), .LVL_W(16), .SHIFT(0)) slow_cmp (
    .a_in(res.data),
    .b_in(slow_fifo_newest),
    .level_in(slow_lvl_r),
    .exceeds_out(slow_diff_hit)
  );

  // proximity, hold-off and ambient update
  always_comb begin
    prox = approach_hit || hover_hit;
    slow_en = slow_diff_hit && !prox;
    caldis_load = low_power ? CALDIS_W'({4'h0, low_power_caldis_count} << LP_CALDIS_SHIFT)
                            : CALDIS_W'({4'h0, full_power_caldis_count} << FP_CALDIS_SHIFT);
    // the hold-off counts this stage's own results, i.e. one step per sequence
    if (prox) begin
      caldis_new = caldis_load;
    end else if (caldis_cur != '0) begin
      caldis_new = caldis_cur - 8'h01;
    end else begin
      caldis_new = caldis_cur;
    end
    cal_ok = !prox && (caldis_cur == '0);
    amb_upd = stage_ok && slow_en && cal_ok;
    amb_delta = {1'b0, res.data} - {1'b0, stage_ambient_estimate};
    amb_step = $signed(amb_delta) >>> AMB_FILTER_SHIFT;
    amb_new = amb_upd ? (stage_ambient_estimate + amb_step[DATA_W-1:0]) : stage_ambient_estimate;
    ulim_new = limit_calc(amb_new, uoff_mem[st], positive_sensitivity);
    llim_new = limit_calc(amb_new, loff_mem[st], negative_sensitivity);
    // compare against limits in force before this result so a crossing cannot mask itself
    cross_up = stage_ok && (res.data > stage_upper_limit);
    cross_low = stage_ok && (res.data < stage_lower_limit);
    prox_rise = stage_ok && prox && !prox_vec_r[st];
    prox_vec_nxt = prox_vec_r;
    if (stage_ok) begin
      prox_vec_nxt[st] = prox;
    end
    prox_out_nxt = |prox_vec_nxt;
    sw_nxt = amb_upd;
    // lowering the skip count below the running count lets the counter wrap through 15 once
    if (seq_end) begin
      skip_cnt_nxt = (skip_cnt_r == fast_skip_count) ? 4'h0 : skip_cnt_r + 4'h1;
    end else begin
      skip_cnt_nxt = skip_cnt_r;
    end
  end

  // register port, status and interrupt
  always_comb begin
    prox_ctrl_nxt = prox_ctrl_r;
    amb_ctrl_nxt = amb_ctrl_r;
    mode_nxt = mode_r;
    slow_lvl_nxt = slow_lvl_r;
    sens_nxt = sens_r;
    sel_nxt = sel_r;
    mask_nxt = mask_r;
    status_nxt = status_r;
    rdata_nxt = 16'h0000;
    if (req.wr) begin
      case (req.addr)
        PROX_CTRL_ADDR: prox_ctrl_nxt = {4'h0, req.wdata[11:0]};
        AMB_CTRL_ADDR: amb_ctrl_nxt = {2'b00, req.wdata[13:0]};
        MODE_ADDR: mode_nxt = {11'h000, req.wdata[4:0]};
        SLOW_LVL_ADDR: slow_lvl_nxt = req.wdata;
        SENS_ADDR: sens_nxt = req.wdata[7:0];
        STAGE_SEL_ADDR: sel_nxt = req.wdata[STAGE_W-1:0];
        MASK_ADDR: mask_nxt = req.wdata[STATUS_W-1:0];
        STATUS_ADDR: status_nxt = status_r & ~req.wdata[STATUS_W-1:0];
        default: ;
      endcase
    end
    // a new event wins over a same-cycle clear
    status_nxt = status_nxt | {prox_rise, cross_low, cross_up};
    int_n_nxt = ~|(status_nxt & mask_nxt);
    if (req.rd) begin
      case (req.addr)
        PROX_CTRL_ADDR: rdata_nxt = prox_ctrl_r;
        AMB_CTRL_ADDR: rdata_nxt = amb_ctrl_r;
        MODE_ADDR: rdata_nxt = mode_r;
        SLOW_LVL_ADDR: rdata_nxt = slow_lvl_r;
        SENS_ADDR: rdata_nxt = {8'h00, sens_r};
        STAGE_SEL_ADDR: rdata_nxt = {12'h000, sel_r};
        UPPER_OFFSET_ADDR: rdata_nxt = uoff_mem[sel_r];
        LOWER_OFFSET_ADDR: rdata_nxt = loff_mem[sel_r];
        AMBIENT_ADDR: rdata_nxt = amb_mem[sel_r];
        UPPER_LIMIT_ADDR: rdata_nxt = ulim_mem[sel_r];
        LOWER_LIMIT_ADDR: rdata_nxt = llim_mem[sel_r];
        STATUS_ADDR: rdata_nxt = {13'h0000, status_r};
        MASK_ADDR: rdata_nxt = {13'h0000, mask_r};
        PROX_FLAGS_ADDR: rdata_nxt = 16'(prox_vec_r);
        SLOW_NEWEST_ADDR: rdata_nxt = slow_mem[sel_r];
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prox_ctrl_r <= PROX_CTRL_RST;
      amb_ctrl_r <= AMB_CTRL_RST;
      mode_r <= MODE_RST;
      slow_lvl_r <= SLOW_LVL_RST;
      sens_r <= SENS_RST;
      sel_r <= '0;
      status_r <= '0;
      mask_r <= '0;
      rdata_r <= 16'h0000;
      int_n_r <= 1'b1;
      prox_out_r <= 1'b0;
      sw_r <= 1'b0;
      skip_cnt_r <= 4'h0;
      prox_vec_r <= '0;
    end else begin
      prox_ctrl_r <= prox_ctrl_nxt;
      amb_ctrl_r <= amb_ctrl_nxt;
      mode_r <= mode_nxt;
      slow_lvl_r <= slow_lvl_nxt;
      sens_r <= sens_nxt;
      sel_r <= sel_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      int_n_r <= int_n_nxt;
      prox_out_r <= prox_out_nxt;
      sw_r <= sw_nxt;
      skip_cnt_r <= skip_cnt_nxt;
      prox_vec_r <= prox_vec_nxt;
    end
  end

  // stage memory: one entry written per result, offsets written by software
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int s = 0; s < N_STAGES; s++) begin
        for (int k = 0; k < FF_DEPTH; k++) begin
          ff_mem[s][k] <= '0;
        end
        slow_mem[s] <= '0;
        amb_mem[s] <= '0;
        uoff_mem[s] <= '0;
        loff_mem[s] <= '0;
        ulim_mem[s] <= UPPER_LIMIT_RST;
        llim_mem[s] <= LOWER_LIMIT_RST;
        caldis_mem[s] <= '0;
      end
    end else begin
      if (stage_ok) begin
        for (int k = 0; k < FF_DEPTH; k++) begin
          ff_mem[st][k] <= ff_new[k];
        end
        if (amb_upd) begin
          slow_mem[st] <= res.data;
        end
        amb_mem[st] <= amb_new;
        ulim_mem[st] <= ulim_new;
        llim_mem[st] <= llim_new;
        caldis_mem[st] <= caldis_new;
      end
      if (req.wr && ({28'h0000000, sel_r} < N_STAGES)) begin
        if (req.addr == UPPER_OFFSET_ADDR) begin
          uoff_mem[sel_r] <= req.wdata;
        end
        if (req.addr == LOWER_OFFSET_ADDR) begin
          loff_mem[sel_r] <= req.wdata;
        end
      end
    end
  end

  assign reg_rdata_out = rdata_r;
  assign int_n_out = int_n_r;
  assign proximity_out = prox_out_r;
  assign slow_path_switch_out = sw_r;

endmodule : proximity_ambient_threshold_logic

// ==== sim/proximity_ambient_threshold_logic_sva.sv ====
// port-level assertions for the proximity and ambient threshold block
`timescale 1ns/1ps
module proximity_ambient_threshold_logic_sva
  import prox_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic res_valid_in,
  input wire logic [STAGE_W-1:0] res_stage_in,
  input wire logic [DATA_W-1:0] res_data_in,
  input wire logic int_n_out,
  input wire logic proximity_out,
  input wire logic slow_path_switch_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  AST_RDATA_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data outside a read answer");
  AST_UNMAPPED_READ: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 10'h3ff |->
    reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  // results may come back to back, so the pulse only has to end when no result follows it
  AST_SWITCH_PULSE: assert property (slow_path_switch_out && !res_valid_in |=> !slow_path_switch_out)
    else $error("switch longer than one cycle");
  AST_SWITCH_CAUSE: assert property ($rose(slow_path_switch_out) |->
    $past(res_valid_in) || $past(res_valid_in, 2))
    else $error("switch without a result");
  AST_INT_SET_CAUSE: assert property ($fell(int_n_out) |->
    $past(res_valid_in) || $past(res_valid_in, 2) || $past(reg_wr_in) || $past(reg_wr_in, 2))
    else $error("interrupt without event or mask write");
  AST_INT_CLEAR_CAUSE: assert property ($rose(int_n_out) |-> $past(reg_wr_in) || $past(reg_wr_in, 2))
    else $error("interrupt released without a write");
  AST_PROX_CAUSE: assert property ($rose(proximity_out) |-> $past(res_valid_in) || $past(res_valid_in, 2))
    else $error("proximity without a result");
  AST_PROX_HOLD: assert property (!$past(res_valid_in) && !$past(res_valid_in, 2) |-> $stable(proximity_out))
    else $error("proximity changed with no result");
endmodule : proximity_ambient_threshold_logic_sva

// ==== sim/proximity_ambient_threshold_logic_test.sv ====
// self-checking bench for the proximity and ambient threshold block
`timescale 1ns/1ps
module proximity_ambient_threshold_logic_test
  import prox_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [ADDR_W-1:0] reg_addr_in = 10'h000;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out;
  logic res_valid_in = 1'b0;
  logic [STAGE_W-1:0] res_stage_in = 4'h0;
  logic [DATA_W-1:0] res_data_in = 16'h0000;
  logic int_n_out;
  logic proximity_out;
  logic slow_path_switch_out;
  logic sw;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  proximity_ambient_threshold_logic dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .res_valid_in(res_valid_in), .res_stage_in(res_stage_in),
    .res_data_in(res_data_in), .int_n_out(int_n_out), .proximity_out(proximity_out),
    .slow_path_switch_out(slow_path_switch_out));

  initial begin
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    check($sformatf("reg %h", a), reg_rdata_out, exp);
  endtask : rchk

  // the switch pulse is collected over the cycles that may carry it
  task automatic res(input logic [3:0] s, input logic [15:0] d);
    @(posedge ref_clk_in);
    res_valid_in <= 1'b1;
    res_stage_in <= s;
    res_data_in <= d;
    @(posedge ref_clk_in);
    res_valid_in <= 1'b0;
    #1;
    sw = slow_path_switch_out;
    repeat (2) begin
      @(posedge ref_clk_in);
      #1;
      sw = sw | slow_path_switch_out;
    end
  endtask : res

  task automatic settle();
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask : settle

  task automatic t_reset();
    logic [ADDR_W-1:0] ra [9];
    logic [15:0] rv [9];
    ra = '{10'h002, 10'h003, 10'h080, 10'h081, 10'h082, 10'h087, 10'h088, 10'h089, 10'h3ff};
    rv = '{16'h0000, 16'h0000, 16'h0016, 16'h0000, 16'h0088, 16'hffff, 16'h0000, 16'h0000, 16'h0000};
    foreach (ra[i]) rchk(ra[i], rv[i]);
    check("int_n", {15'h0000, int_n_out}, 16'h0001);
  endtask : t_reset

  // offsets chosen so that the quarter divisions truncate
  task automatic t_thresh();
    wr(10'h003, 16'h3fff);
    wr(10'h002, 16'h0010);
    rchk(10'h002, 16'h0010);
    wr(10'h083, 16'h0000);
    wr(10'h084, 16'h0103);
    wr(10'h085, 16'h0042);
    wr(10'h3ff, 16'h1234);
    rchk(10'h3ff, 16'h0000);
    res(4'h0, 16'h0200);
    check("switch", {15'h0000, sw}, 16'h0001);
    rchk(10'h086, 16'h0020);
    rchk(10'h087, 16'h01e0);
    rchk(10'h088, 16'h0090);
    rchk(10'h08c, 16'h0200);
    rchk(10'h089, 16'h0000);
  endtask : t_thresh

  task automatic t_irq();
    res(4'h0, 16'h0300);
    rchk(10'h089, 16'h0001);
    check("int_n", {15'h0000, int_n_out}, 16'h0001);
    wr(10'h08a, 16'h0001);
    settle();
    check("int_n", {15'h0000, int_n_out}, 16'h0000);
    res(4'h0, 16'h0010);
    rchk(10'h089, 16'h0003);
    wr(10'h089, 16'h0001);
    settle();
    check("int_n", {15'h0000, int_n_out}, 16'h0001);
    rchk(10'h089, 16'h0002);
    wr(10'h089, 16'h0002);
  endtask : t_irq

  // approach level 1 means a difference of exactly 16 must not count
  task automatic t_prox();
    wr(10'h003, 16'h01ff);
    res(4'h2, 16'h0010);
    check("switch", {15'h0000, sw}, 16'h0001);
    check("prox", {15'h0000, proximity_out}, 16'h0000);
    res(4'h1, 16'h0011);
    check("switch", {15'h0000, sw}, 16'h0000);
    check("prox", {15'h0000, proximity_out}, 16'h0001);
    wr(10'h083, 16'h0002);
    rchk(10'h086, 16'h0001);
    wr(10'h083, 16'h0001);
    rchk(10'h086, 16'h0000);
    rchk(10'h089, 16'h0004);
    wr(10'h089, 16'h0004);
  endtask : t_prox

  task automatic t_hold();
    wr(10'h003, 16'h3f01);
    res(4'h3, 16'h0044);
    res(4'h4, 16'h0043);
    rchk(10'h08b, 16'h000a);
    repeat (4) res(4'h3, 16'h0000);
    rchk(10'h08b, 16'h0002);
    res(4'h3, 16'h0020);
    check("switch", {15'h0000, sw}, 16'h0000);
    wr(10'h083, 16'h0003);
    rchk(10'h086, 16'h0000);
    res(4'hc, 16'hffff);
    check("switch", {15'h0000, sw}, 16'h0000);
    check("prox", {15'h0000, proximity_out}, 16'h0001);
  endtask : t_hold

  task automatic t_rereset();
    @(posedge ref_clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    rchk(10'h089, 16'h0000);
    rchk(10'h08b, 16'h0000);
    check("prox", {15'h0000, proximity_out}, 16'h0000);
  endtask : t_rereset

  // one stage per sequence, every other sample kept, low power hold-off of four results
  task automatic t_skip();
    wr(10'h002, 16'h0101);
    wr(10'h080, 16'h0001);
    wr(10'h003, 16'h01ff);
    wr(10'h084, 16'hffff);
    res(4'h0, 16'h0100);
    check("prox", {15'h0000, proximity_out}, 16'h0000);
    res(4'h0, 16'h0100);
    check("prox", {15'h0000, proximity_out}, 16'h0001);
    repeat (6) res(4'h0, 16'h0100);
    check("prox", {15'h0000, proximity_out}, 16'h0000);
    repeat (3) begin
      res(4'h0, 16'h0108);
      check("switch", {15'h0000, sw}, 16'h0000);
    end
    res(4'h0, 16'h0108);
    check("switch", {15'h0000, sw}, 16'h0001);
    rchk(10'h086, 16'h001f);
    rchk(10'h087, 16'hffff);
  endtask : t_skip

  initial begin
    repeat (4) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_thresh();
    t_irq();
    t_prox();
    t_hold();
    t_rereset();
    t_skip();
    give_verdict();
  end
endmodule : proximity_ambient_threshold_logic_test

bind proximity_ambient_threshold_logic proximity_ambient_threshold_logic_sva chk (.ref_clk_in(ref_clk_in),
  .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .res_valid_in(res_valid_in),
  .res_stage_in(res_stage_in), .res_data_in(res_data_in), .int_n_out(int_n_out),
  .proximity_out(proximity_out), .slow_path_switch_out(slow_path_switch_out));
